// ==== src/lcd_port_defs.vh ====
// constants shared by the lcd host port design files
// assumes inclusion by bare name from files in the same folder
`ifndef LCD_PORT_DEFS_VH
`define LCD_PORT_DEFS_VH

// serial link pin positions on the data lines
`define LCD_SDI_BIT        3'd7
`define LCD_SCLK_BIT       3'd6

// serial bit counter reset value and last-bit index
`define LCD_BITCNT_RESET   3'h0
`define LCD_BITCNT_LAST    3'h7

// bias-select command: top five bits match, low three bits carry the ratio index
`define LCD_BIAS_CMD_MASK  8'hf8
`define LCD_BIAS_CMD_VAL   8'h50
`define LCD_BIAS_IDX_MAX   3'h5
// index 0 is one quarter, index 5 is one ninth
`define LCD_BIAS_RESET     3'h5
`define LCD_BIAS_DEN_BASE  4'h4

// read-data register reset value
`define LCD_DOUT_RESET     8'h00

`endif

// ==== src/lcd_byte_buf.v ====
// two-entry valid/ready buffer for received bytes
// assumes a single clock; clr_i empties the buffer synchronously
`default_nettype none

module lcd_byte_buf #(
	parameter W = 9
) (
	// clock and reset
	input  wire         clk_i,
	input  wire         rst_i,
	input  wire         clr_i,
	// filling side
	input  wire         in_valid_i,
	input  wire [W-1:0] in_data_i,
	output wire         in_ready_o,
	// draining side
	output reg          out_valid_o,
	output reg  [W-1:0] out_data_o,
	input  wire         out_ready_i
);

	reg  [W-1:0] spare;
	reg          spare_valid;
	wire         push;
	wire         pop;

	assign in_ready_o = ~spare_valid;
	assign push       = in_valid_i & ~spare_valid;
	assign pop        = out_valid_o & out_ready_i;

	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			out_valid_o <= 1'b0;
			out_data_o  <= {W{1'b0}};
			spare       <= {W{1'b0}};
			spare_valid <= 1'b0;
		end
		else if (clr_i)
		begin
			out_valid_o <= 1'b0;
			spare_valid <= 1'b0;
		end
		else if (pop)
		begin
			if (spare_valid)
			begin
				// spare moves to head; no push possible while spare is full
				out_data_o  <= spare;
				spare_valid <= 1'b0;
			end
			else
			begin
				out_valid_o <= push;
				if (push)
					out_data_o <= in_data_i;
			end
		end
		else if (push)
		begin
			if (!out_valid_o)
			begin
				out_data_o  <= in_data_i;
				out_valid_o <= 1'b1;
			end
			else
			begin
				spare       <= in_data_i;
				spare_valid <= 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

// ==== src/lcd_bias_levels.v ====
// bias ratio register and the four intermediate level fractions
// assumes set_i is a one-cycle pulse; clr_i returns the ratio to its reset value
`default_nettype none

`include "lcd_port_defs.vh"

module lcd_bias_levels (
	// clock and reset
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       clr_i,
	// ratio update
	input  wire       set_i,
	input  wire [2:0] idx_i,
	// level fractions of the top voltage, numerator over den_o
	output reg  [3:0] den_o,
	output reg  [3:0] v1_num_o,
	output reg  [3:0] v2_num_o,
	output reg  [3:0] v3_num_o,
	output reg  [3:0] v4_num_o
);

	reg  [2:0] idx;
	wire [3:0] den;

	assign den = `LCD_BIAS_DEN_BASE + {1'b0, idx};

	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			idx <= `LCD_BIAS_RESET;
		else if (clr_i)
			idx <= `LCD_BIAS_RESET;
		else if (set_i && idx_i <= `LCD_BIAS_IDX_MAX)
			idx <= idx_i;
	end

	// V1 = (n-1)/n, V2 = (n-2)/n, V3 = 2/n, V4 = 1/n of the top voltage
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			den_o    <= 4'h0;
			v1_num_o <= 4'h0;
			v2_num_o <= 4'h0;
			v3_num_o <= 4'h0;
			v4_num_o <= 4'h0;
		end
		else
		begin
			den_o    <= den;
			v1_num_o <= den - 4'h1;
			v2_num_o <= den - 4'h2;
			v3_num_o <= 4'h2;
			v4_num_o <= 4'h1;
		end
	end

endmodule

`default_nettype wire

// ==== src/lcd_host_port.v ====
// host access port of a dot-matrix lcd controller: parallel (two bus styles) and write-only serial
// assumes all pins are already synchronous to clk_i; the core behind it drains received bytes
// and supplies read data on rd_data_i
`default_nettype none

`include "lcd_port_defs.vh"

module lcd_host_port (
	// clock and reset
	input  wire       clk_i,
	input  wire       rst_i,
	// host pins
	input  wire       chip_sel_low_n_i,
	input  wire       init_n_i,
	input  wire       cmd_data_select_i,
	input  wire       wr_n_i,
	input  wire       rd_n_i,
	input  wire [7:0] host_data_lines_i,
	output reg  [7:0] host_data_lines_o,
	output reg        host_data_lines_oe_n_o,
	// static straps
	input  wire       bus_style_pick_i,
	input  wire       par_ser_pick_i,
	input  wire       internal_divider_pick_i,
	input  wire       power_on_i,
	// received bytes toward the core, bit 8 is the select level
	output wire       rx_valid_o,
	output wire [7:0] rx_data_o,
	output wire       rx_is_data_o,
	input  wire       rx_ready_i,
	// readback from the core
	input  wire [7:0] rd_data_i,
	output reg        rd_done_o,
	output reg        rd_is_data_o,
	// status
	output reg        busy_o,
	output reg        overrun_o,
	output reg        use_internal_divider_o,
	// bias level fractions
	output wire [3:0] bias_den_o,
	output wire [3:0] bias_v1_num_o,
	output wire [3:0] bias_v2_num_o,
	output wire [3:0] bias_v3_num_o,
	output wire [3:0] bias_v4_num_o
);

	localparam [2:0] S_IDLE = 3'b001;
	localparam [2:0] S_WR   = 3'b010;
	localparam [2:0] S_RD   = 3'b100;

	reg  [2:0] state;
	reg  [2:0] next_state;
	reg  [7:0] wr_byte;
	reg        wr_sel;
	reg  [6:0] shift;
	reg  [2:0] bit_cnt;
	reg        sclk_q;
	reg        push_q;
	reg  [7:0] push_byte;
	reg        push_sel;

	wire       clr;
	wire       cs;
	wire       par_mode;
	wire       ser_mode;
	reg        wr_act;
	reg        rd_act;
	wire       sclk;
	wire       sdi;
	wire       sclk_rise;
	wire       in_ready;
	wire       par_push;
	wire       ser_push;
	wire       bias_cmd;
	wire       bias_set;
	wire [8:0] buf_out;

	// the initialization pin clears settings synchronously so async reset stays constant-only
	assign clr = ~init_n_i;
	assign cs  = ~chip_sel_low_n_i;

	// the parallel/serial strap is static; named decodes keep the gating below readable
	assign par_mode = par_ser_pick_i;
	assign ser_mode = ~par_ser_pick_i;

	// enable style: E on the read pin, direction on the write pin
	always @*
	begin
		if (bus_style_pick_i)
		begin
			// E high times the transfer and the direction line picks which one
			wr_act = rd_n_i & ~wr_n_i;
			rd_act = rd_n_i & wr_n_i;
		end
		else
		begin
			// strobe pair: each strobe is active low on its own pin
			wr_act = ~wr_n_i;
			rd_act = ~rd_n_i;
		end
	end

	assign sdi       = host_data_lines_i[`LCD_SDI_BIT];
	assign sclk      = host_data_lines_i[`LCD_SCLK_BIT];
	// sclk_q follows the pin in every mode, so entering serial mode with the clock line high fakes no edge
	assign sclk_rise = sclk & ~sclk_q;

	// the write ends when the strobe (or E) drops away; a deselect first aborts it
	assign par_push = (state == S_WR) & cs & ~wr_act;
	// the select level is taken with the eighth bit, not when the frame closes
	assign ser_push = cs & ser_mode & sclk_rise & (bit_cnt == `LCD_BITCNT_LAST);

	// the byte still goes to the core; only the ratio update needs the power circuit on
	assign bias_cmd = ((push_byte & `LCD_BIAS_CMD_MASK) == `LCD_BIAS_CMD_VAL);
	assign bias_set = push_q & ~push_sel & power_on_i & bias_cmd;

	always @*
	begin
		next_state = state;
		case (state)
			S_IDLE:
			begin
				// serial mode never enters a parallel transfer, so no readback there
				if (cs && par_mode && wr_act)
					next_state = S_WR;
				else if (cs && par_mode && rd_act)
					next_state = S_RD;
			end
			S_WR:
			begin
				if (!cs || !wr_act)
					next_state = S_IDLE;
			end
			S_RD:
			begin
				if (!cs || !rd_act)
					next_state = S_IDLE;
			end
			default:
				next_state = S_IDLE;
		endcase
	end

	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state                  <= S_IDLE;
			wr_byte                <= 8'h00;
			wr_sel                 <= 1'b0;
			host_data_lines_o      <= `LCD_DOUT_RESET;
			host_data_lines_oe_n_o <= 1'b1;
			rd_done_o              <= 1'b0;
			rd_is_data_o           <= 1'b0;
		end
		else if (clr)
		begin
			state                  <= S_IDLE;
			host_data_lines_oe_n_o <= 1'b1;
			rd_done_o              <= 1'b0;
		end
		else
		begin
			state <= next_state;
			// keep the last byte seen while the strobe is active: the rising edge
			// is seen one cycle late, by which time the host may have moved on
			if (next_state == S_WR)
			begin
				wr_byte <= host_data_lines_i;
				wr_sel  <= cmd_data_select_i;
			end
			// core data is taken once at entry; a long read shows no later update
			if (state == S_IDLE && next_state == S_RD)
			begin
				host_data_lines_o <= rd_data_i;
				rd_is_data_o      <= cmd_data_select_i;
			end
			host_data_lines_oe_n_o <= ~(next_state == S_RD);
			// lets the core advance its read address once per completed read
			rd_done_o              <= (state == S_RD) & (next_state == S_IDLE);
		end
	end

	// serial receiver, msb first
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sclk_q  <= 1'b0;
			shift   <= 7'h00;
			bit_cnt <= `LCD_BITCNT_RESET;
		end
		else
		begin
			sclk_q <= sclk;
			if (clr || !cs || par_mode)
				bit_cnt <= `LCD_BITCNT_RESET;
			else if (sclk_rise)
			begin
				shift   <= {shift[5:0], sdi};
				bit_cnt <= bit_cnt + 3'h1;
			end
		end
	end

	// one registered push toward the buffer from whichever receiver finished
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			push_q    <= 1'b0;
			push_byte <= 8'h00;
			push_sel  <= 1'b0;
			overrun_o <= 1'b0;
			busy_o    <= 1'b0;
		end
		else if (clr)
		begin
			push_q    <= 1'b0;
			overrun_o <= 1'b0;
			busy_o    <= 1'b0;
		end
		else
		begin
			push_q <= par_push | ser_push;
			if (par_push)
			begin
				push_byte <= wr_byte;
				push_sel  <= wr_sel;
			end
			else if (ser_push)
			begin
				push_byte <= {shift, sdi};
				push_sel  <= cmd_data_select_i;
			end
			// the host cannot be stalled mid-strobe; it must watch busy, a byte sent anyway is lost
			if (push_q && !in_ready)
				overrun_o <= 1'b1;
			busy_o <= ~in_ready;
		end
	end

	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			use_internal_divider_o <= 1'b0;
		else
			// only the choice is passed on; the divider itself sits outside this port
			use_internal_divider_o <= internal_divider_pick_i;
	end

	// two entries so a core stall of one byte loses nothing
	lcd_byte_buf #(
		.W (9)
	) u_buf (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.clr_i       (clr),
		.in_valid_i  (push_q),
		.in_data_i   ({push_sel, push_byte}),
		.in_ready_o  (in_ready),
		.out_valid_o (rx_valid_o),
		.out_data_o  (buf_out),
		.out_ready_i (rx_ready_i)
	);

	assign rx_data_o    = buf_out[7:0];
	assign rx_is_data_o = buf_out[8];

	// the ratio index rides in the low three bits of the pushed command byte
	lcd_bias_levels u_bias (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.clr_i    (clr),
		.set_i    (bias_set),
		.idx_i    (push_byte[2:0]),
		.den_o    (bias_den_o),
		.v1_num_o (bias_v1_num_o),
		.v2_num_o (bias_v2_num_o),
		.v3_num_o (bias_v3_num_o),
		.v4_num_o (bias_v4_num_o)
	);

endmodule

`default_nettype wire

// ==== bench/lcd_host_port_sva.sv ====
// concurrent checks on the lcd host port pins and core side, bound into the port
// assumes one clock with the active-high asynchronous reset of the port
`default_nettype none

module lcd_host_port_chk (
	// clock and reset
	input wire logic	clk_i,
	input wire logic	rst_i,
	// host pins and straps
	input wire logic	chip_sel_low_n_i,
	input wire logic	init_n_i,
	input wire logic	cmd_data_select_i,
	input wire logic	wr_n_i,
	input wire logic	rd_n_i,
	input wire logic [7:0]	host_data_lines_i,
	input wire logic [7:0]	host_data_lines_o,
	input wire logic	host_data_lines_oe_n_o,
	input wire logic	bus_style_pick_i,
	input wire logic	par_ser_pick_i,
	// core side and status
	input wire logic	rx_valid_o,
	input wire logic [7:0]	rx_data_o,
	input wire logic	rx_is_data_o,
	input wire logic	rx_ready_i,
	input wire logic [7:0]	rd_data_i,
	input wire logic	busy_o,
	input wire logic [3:0]	bias_den_o,
	input wire logic [3:0]	bias_v1_num_o,
	input wire logic [3:0]	bias_v4_num_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// last byte seen under the write strobe; the delivery latency may vary by one edge
	logic [8:0]	wr_byte;
	always @(posedge clk_i)
		if (!wr_n_i)
			wr_byte <= {cmd_data_select_i, host_data_lines_i};

	sequence wr_end;
		par_ser_pick_i && !bus_style_pick_i && init_n_i && !chip_sel_low_n_i && wr_n_i && !$past(wr_n_i)
			&& !$past(chip_sel_low_n_i) && !rx_valid_o && !busy_o;
	endsequence
	sequence byte_out;
		##[1:3] rx_valid_o && {rx_is_data_o, rx_data_o} == wr_byte;
	endsequence

	write_cap_a:
	assert property (wr_end |-> byte_out) else $error("written byte not delivered");
	cs_release_a:
	assert property (chip_sel_low_n_i [*2] |-> host_data_lines_oe_n_o) else $error("bus driven unselected");
	ser_release_a:
	assert property (!par_ser_pick_i |-> host_data_lines_oe_n_o) else $error("bus driven in serial mode");
	read_start_a:
	assert property ($fell(host_data_lines_oe_n_o) |-> !$past(chip_sel_low_n_i) && ($past(bus_style_pick_i) ?
		$past(rd_n_i) && $past(wr_n_i) : !$past(rd_n_i)) && host_data_lines_o == $past(rd_data_i))
		else $error("bad read start");
	read_hold_a:
	assert property (!host_data_lines_oe_n_o && !bus_style_pick_i && !rd_n_i && wr_n_i && !chip_sel_low_n_i
		&& init_n_i |=> !host_data_lines_oe_n_o) else $error("read dropped early");
	init_clear_a:
	assert property (!init_n_i |=> !rx_valid_o && host_data_lines_oe_n_o ##1 bias_den_o == 4'h9)
		else $error("init did not clear");
	rx_keep_a:
	assert property (rx_valid_o && !rx_ready_i && init_n_i |=> rx_valid_o && $stable(rx_data_o)
		&& $stable(rx_is_data_o)) else $error("stalled byte lost");
	bias_frac_a:
	assert property (bias_den_o != 4'h0 |-> bias_den_o >= 4'h4 && bias_den_o <= 4'h9
		&& bias_v1_num_o == bias_den_o - 4'h1 && bias_v4_num_o == 4'h1)
		else $error("bias fractions wrong");
endmodule

bind lcd_host_port lcd_host_port_chk chk_inst (.clk_i, .rst_i, .chip_sel_low_n_i, .init_n_i, .cmd_data_select_i,
	.wr_n_i, .rd_n_i, .host_data_lines_i, .host_data_lines_o, .host_data_lines_oe_n_o, .bus_style_pick_i,
	.par_ser_pick_i, .rx_valid_o, .rx_data_o, .rx_is_data_o, .rx_ready_i, .rd_data_i, .busy_o, .bias_den_o,
	.bias_v1_num_o, .bias_v4_num_o);
`default_nettype wire

// ==== bench/host_model.sv ====
// host processor model on the lcd port pins: two parallel styles and serial writes
// assumes the bench resolves the data lines and returns them on bus_i
`default_nettype none

module host_model (
	// clock and resolved data lines
	input wire logic	clk_i,
	input wire logic [7:0]	bus_i,
	// host pins
	output logic		cs_n_o,
	output logic		sel_o,
	output logic		wr_n_o,
	output logic		rd_n_o,
	output logic [7:0]	dat_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		cs_n_o = 1'b1;
		sel_o = 1'b0;
		wr_n_o = 1'b1;
		rd_n_o = 1'b1;
		dat_o = 8'h00;
	end

	// st picks the enable style; c high leaves the device deselected
	task automatic pw(input logic st, input logic s, input logic [7:0] d, input logic c);
		@(posedge clk_i);
		cs_n_o <= c;
		sel_o <= s;
		dat_o <= d;
		wr_n_o <= 1'b0;
		rd_n_o <= 1'b1;
		repeat (2) @(posedge clk_i);
		wr_n_o <= 1'b1;
		rd_n_o <= !st;
		@(posedge clk_i);
		cs_n_o <= 1'b1;
		dat_o <= ~d;
	endtask

	task automatic pr(input logic st, input logic c, output logic [7:0] q);
		@(posedge clk_i);
		cs_n_o <= c;
		wr_n_o <= 1'b1;
		rd_n_o <= st;
		dat_o <= ~dat_o;
		repeat (3) @(posedge clk_i);
		q = bus_i;
		rd_n_o <= !st;
		@(posedge clk_i);
		cs_n_o <= 1'b1;
	endtask

	// strobes stay put; the serial clock rests low outside a frame
	task automatic sb(input logic s, input logic [7:0] d, input int n);
		for (int i = 7; i > 7 - n; i--)
		begin
			@(posedge clk_i);
			cs_n_o <= 1'b0;
			sel_o <= s;
			dat_o <= {d[i], 7'h00};
			@(posedge clk_i);
			dat_o[6] <= 1'b1;
		end
		@(posedge clk_i);
		dat_o <= 8'h00;
		@(posedge clk_i);
		cs_n_o <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ==== bench/test_lcd_host_port.sv ====
// self-checking bench for the lcd host port: host model on the pins, core side driven here
// assumes the host model and the checker are compiled before this file
`default_nettype none

`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end

module test_lcd_host_port;
	timeunit 1ns;
	timeprecision 1ps;

	logic		clk_i = 1'b0;
	logic		rst_i = 1'b1;
	logic		init_n_i = 1'b1;
	logic		style = 1'b0;
	logic		par = 1'b1;
	logic		divp = 1'b0;
	logic		pwr = 1'b1;
	logic		rdy = 1'b1;
	logic [7:0]	rdd = 8'h00;
	logic [7:0]	d;
	logic [7:0]	q;
	logic		s;
	logic [8:0]	rxq[$];
	integer		seed = 32'ha2e0bbe3;
	int		mismatches = 0;
	int		compares = 0;
	int		cycles = 0;
	int		reads = 0;
	wire		cs_n, sel, wr_n, rd_n, oe_n, rxv, rxs, busy, ovr, div, rd_done, rd_sel;
	wire [7:0]	hd, dev_o, bus, rxd;
	wire [3:0]	den, v1, v2, v3, v4;

	always #2.5 clk_i = ~clk_i;
	assign bus = oe_n ? hd : dev_o;
	always @(posedge clk_i)
		if (rxv && rdy)
			rxq.push_back({rxs, rxd});
	always @(posedge clk_i)
		if (rd_done)
			reads++;
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			mismatches++;
			give_verdict;
		end
	end

	host_model host_model_inst (.clk_i(clk_i), .bus_i(bus), .cs_n_o(cs_n), .sel_o(sel), .wr_n_o(wr_n),
		.rd_n_o(rd_n), .dat_o(hd));
	lcd_host_port lcd_host_port_inst (.clk_i(clk_i), .rst_i(rst_i), .chip_sel_low_n_i(cs_n), .init_n_i(init_n_i),
		.cmd_data_select_i(sel), .wr_n_i(wr_n), .rd_n_i(rd_n), .host_data_lines_i(bus), .host_data_lines_o(dev_o),
		.host_data_lines_oe_n_o(oe_n), .bus_style_pick_i(style), .par_ser_pick_i(par),
		.internal_divider_pick_i(divp), .power_on_i(pwr), .rx_valid_o(rxv), .rx_data_o(rxd), .rx_is_data_o(rxs),
		.rx_ready_i(rdy), .rd_data_i(rdd), .rd_done_o(rd_done), .rd_is_data_o(rd_sel),
		.busy_o(busy), .overrun_o(ovr),
		.use_internal_divider_o(div), .bias_den_o(den), .bias_v1_num_o(v1), .bias_v2_num_o(v2),
		.bias_v3_num_o(v3), .bias_v4_num_o(v4));

	task automatic give_verdict;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic take(input logic es, input logic [7:0] e);
		int k;
		k = 0;
		while (rxq.size() == 0 && k < 40)
		begin
			@(posedge clk_i);
			k++;
		end
		`CHK("rx byte", {es, e}, rxq.size() ? rxq[0] : 9'hxxx);
		if (rxq.size())
			rxq.delete(0);
	endtask

	task automatic pulse_init;
		init_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		init_n_i <= 1'b1;
		@(posedge clk_i);
	endtask

	// level numerators follow n-1, n-2, 2, 1 over n
	function automatic logic [19:0] bias_exp(input int i);
		logic [3:0] n;
		n = 4'h4 + i[3:0];
		return {n, n - 4'h1, n - 4'h2, 4'h2, 4'h1};
	endfunction

	initial
	begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int st = 0; st < 2; st++)
		begin
			style <= st[0];
			divp <= 1'($random(seed));
			repeat (4)
			begin
				d = 8'($random(seed));
				s = 1'($random(seed));
				host_model_inst.pw(st[0], s, d, 1'b0);
				take(s, d);
				rdd <= 8'($random(seed));
				host_model_inst.pr(st[0], 1'b0, q);
				`CHK("read", rdd, q);
				`CHK("read sel", s, rd_sel);
			end
			host_model_inst.pw(st[0], 1'b1, 8'hff, 1'b1);
			repeat (8) @(posedge clk_i);
			`CHK("deselect", 0, rxq.size());
			`CHK("read done", 4 * (st + 1), reads);
			`CHK("divider", divp, div);
			$display("test parallel style %0d done", st);
		end
		// a partial frame first: deselect must drop its bits
		// read strobe stays parked low in strobe-pair style: only the serial strap keeps the bus released
		par <= 1'b0;
		style <= 1'b0;
		d = 8'($random(seed));
		s = 1'($random(seed));
		host_model_inst.sb(s, ~d, 3);
		host_model_inst.sb(s, d, 8);
		take(s, d);
		repeat (8) @(posedge clk_i);
		`CHK("serial extra", 0, rxq.size());
		`CHK("serial reads", 8, reads);
		$display("test serial done");
		par <= 1'b1;
		style <= 1'b0;
		for (int i = 6; i >= 0; i--)
		begin
			host_model_inst.pw(1'b0, 1'b0, 8'h50 | i[7:0], 1'b0);
			repeat (6) @(posedge clk_i);
			`CHK("bias", bias_exp(i == 6 ? 5 : i), {den, v1, v2, v3, v4});
		end
		pwr <= 1'b0;
		host_model_inst.pw(1'b0, 1'b0, 8'h55, 1'b0);
		repeat (6) @(posedge clk_i);
		`CHK("bias unpowered", bias_exp(0), {den, v1, v2, v3, v4});
		pulse_init;
		`CHK("bias init", bias_exp(5), {den, v1, v2, v3, v4});
		rxq.delete();
		$display("test bias done");
		rdy <= 1'b0;
		for (int i = 0; i < 3; i++)
			host_model_inst.pw(1'b0, 1'b1, 8'h10 + i[7:0], 1'b0);
		repeat (4) @(posedge clk_i);
		`CHK("full", 2'b11, {busy, ovr});
		rdy <= 1'b1;
		take(1'b1, 8'h10);
		take(1'b1, 8'h11);
		repeat (6) @(posedge clk_i);
		`CHK("dropped", 0, rxq.size());
		rdy <= 1'b0;
		host_model_inst.pw(1'b0, 1'b1, 8'h3c, 1'b0);
		repeat (4) @(posedge clk_i);
		pulse_init;
		`CHK("init", 3'b000, {ovr, rxv, busy});
		$display("test buffer done");
		give_verdict;
	end
endmodule
`default_nettype wire
